/* inc/lsd_pkg.sv */
// ==========================================================================
// lsd_pkg: constants shared by the lcd segment driver core
package lsd_pkg;

    // ======================================================================
    // geometry
    localparam int STAGES      = 160;
    localparam int SEGS        = 80;
    localparam int LATCH_WORDS = 5;

    // ======================================================================
    // register offsets (byte addresses, low eight address bits)
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] LATCH_OFS = 8'h10;

    // ======================================================================
    // control register fields
    localparam int         CTRL_W         = 4;
    localparam int         CTRL_DYN_BIT   = 0;
    localparam int         CTRL_EXT_BIT   = 1;
    localparam int         CTRL_TEST_BIT  = 2;
    localparam int         CTRL_BLANK_BIT = 3;
    localparam logic [3:0] CTRL_RESET     = 4'h0;

    // ======================================================================
    // pin synchroniser lanes
    localparam int PIN_W     = 5;
    localparam int PIN_SCLK  = 0;
    localparam int PIN_SDATA = 1;
    localparam int PIN_LOAD  = 2;
    localparam int PIN_OSC   = 3;
    localparam int PIN_ALIGN = 4;

    // ======================================================================
    // common generator
    localparam int DIV_W          = 3;
    localparam int STATIC_DIV_BIT = 2;
    localparam int DYN_DIV_BIT    = 1;

    // ======================================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int ALIGN_LOW_NS  = 200;
    localparam int ALIGN_LOW_CYC =
        (ALIGN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALIGN_CNT_W   = 4;

    // ======================================================================
    // backplane drive levels
    typedef enum logic [1:0] {
        LVL_LOW  = 2'b00,
        LVL_MID  = 2'b01,
        LVL_HIGH = 2'b10
    } lsd_level_type;

endpackage : lsd_pkg

/* design/lsd_core.sv */
`timescale 1ns/1ps
// ==========================================================================
// Summary of operation
// - serial bit shifts in on clock rise
// - load high copies shift into latch
// - data bit one turns segment on
// - internal common divides oscillator by 8/4
// - external select uses oscillator input as common
// - duty select high means dynamic mode
// - expander: oscillator high inverts segment outputs
// - first cascade output shows stage 80
// - second cascade output shows stage 160
// - static: both backplanes follow common reference
// - dynamic: backplanes alternate select each cycle
// - non-selected backplane drives middle level
// - dynamic: halves follow backplane selection
// - static: first latch half only
// - on segment anti-phase, off in phase
// - test input forces all segments on
// - blank forces all off unless test
// - shared align line syncs backplane phases
module lsd_core (
    // bus clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // serial display data
    input  wire logic                  serial_clock,
    input  wire logic                  serial_data,
    input  wire logic                  load_strobe,
    output logic                       cascade_out_stage80,
    output logic                       cascade_out_stage160,
    // common timing
    input  wire logic                  oscillator_input,
    output logic                       common_reference_out,
    // phase alignment line
    input  wire logic                  phase_align_in,
    output logic                       phase_align_out,
    output logic                       phase_align_oe,
    // panel drive
    output lsd_pkg::lsd_level_type     backplane_first,
    output lsd_pkg::lsd_level_type     backplane_second,
    output logic [lsd_pkg::SEGS-1:0]   segment_outputs
);

    // ======================================================================
    // declarations
    logic [lsd_pkg::PIN_W-1:0]       pin_s1_r, pin_s1_nxt;
    logic [lsd_pkg::PIN_W-1:0]       pin_s2_r, pin_s2_nxt;
    logic [lsd_pkg::PIN_W-1:0]       pin_s3_r, pin_s3_nxt;
    logic                            sclk_rise;
    logic                            osc_tick;
    logic                            data_s;
    logic                            load_s;
    logic                            osc_s;
    logic                            align_s;
    logic [lsd_pkg::STAGES-1:0]      shift_r, shift_nxt;
    logic [lsd_pkg::STAGES-1:0]      latch_r, latch_nxt;
    logic [lsd_pkg::DIV_W-1:0]       div_r, div_nxt;
    logic                            com_r, com_nxt;
    logic [1:0]                      phase_r, phase_nxt;
    logic [lsd_pkg::ALIGN_CNT_W-1:0] align_cnt_r, align_cnt_nxt;
    logic                            align_oe_r, align_oe_nxt;
    logic                            sel_b;
    logic                            dyn;
    logic                            ext;
    logic                            test;
    logic                            blank;
    lsd_pkg::lsd_level_type          bp1_r, bp1_nxt;
    lsd_pkg::lsd_level_type          bp2_r, bp2_nxt;
    logic [lsd_pkg::SEGS-1:0]        seg_r, seg_nxt;
    logic                            cref_r, cref_nxt;
    logic [lsd_pkg::CTRL_W-1:0]      ctrl_r, ctrl_nxt;
    logic [lsd_pkg::CTRL_W-1:0]      ctrl_eff;
    logic                            wr_pend_r, wr_pend_nxt;
    logic [7:0]                      wr_addr_r, wr_addr_nxt;
    logic [31:0]                     rdata_r, rdata_nxt;
    logic                            take;

    // ======================================================================
    // pin synchronisers
    always_comb begin
        pin_s1_nxt = {phase_align_in, oscillator_input, load_strobe,
                      serial_data, serial_clock};
        pin_s2_nxt = pin_s1_r;
        pin_s3_nxt = pin_s2_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= 5'h1_0;
            pin_s2_r <= 5'h1_0;
            pin_s3_r <= 5'h1_0;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
            pin_s3_r <= pin_s3_nxt;
        end
    end

    assign data_s    = pin_s2_r[lsd_pkg::PIN_SDATA];
    assign load_s    = pin_s2_r[lsd_pkg::PIN_LOAD];
    assign osc_s     = pin_s2_r[lsd_pkg::PIN_OSC];
    assign align_s   = pin_s2_r[lsd_pkg::PIN_ALIGN];
    assign sclk_rise = pin_s2_r[lsd_pkg::PIN_SCLK]
                     & ~pin_s3_r[lsd_pkg::PIN_SCLK];
    assign osc_tick  = osc_s & ~pin_s3_r[lsd_pkg::PIN_OSC];

    // ======================================================================
    // shift register and display latch
    always_comb begin
        shift_nxt = shift_r;
        if (sclk_rise) begin
            shift_nxt = {shift_r[lsd_pkg::STAGES-2:0], data_s};
        end
        latch_nxt = load_s ? shift_r : latch_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_r <= '0;
            latch_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            latch_r <= latch_nxt;
        end
    end

    assign cascade_out_stage80  = shift_r[lsd_pkg::SEGS-1];
    assign cascade_out_stage160 = shift_r[lsd_pkg::STAGES-1];

    // ======================================================================
    // common generator and phase alignment
    assign dyn   = ctrl_r[lsd_pkg::CTRL_DYN_BIT];
    assign ext   = ctrl_r[lsd_pkg::CTRL_EXT_BIT];
    assign test  = ctrl_r[lsd_pkg::CTRL_TEST_BIT];
    assign blank = ctrl_r[lsd_pkg::CTRL_BLANK_BIT];
    assign sel_b = phase_r[0] ^ phase_r[1];

    always_comb begin
        div_nxt = osc_tick ? div_r + 3'h1 : div_r;
        if (ext) begin
            com_nxt = osc_s;
        end else if (dyn) begin
            com_nxt = div_r[lsd_pkg::DYN_DIV_BIT];
        end else begin
            com_nxt = div_r[lsd_pkg::STATIC_DIV_BIT];
        end
        phase_nxt = (com_nxt != com_r) ? phase_r + 2'h1 : phase_r;
        align_cnt_nxt = (align_cnt_r != '0) ? align_cnt_r - 4'h1
                                            : align_cnt_r;
        if (dyn && (com_nxt != com_r) && (phase_r == 2'h3)) begin
            align_cnt_nxt = 4'(lsd_pkg::ALIGN_LOW_CYC);
        end
        if (dyn && !align_s) begin
            phase_nxt = 2'h0;
        end
        align_oe_nxt = (align_cnt_nxt != '0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r       <= '0;
            com_r       <= 1'b0;
            phase_r     <= 2'h0;
            align_cnt_r <= '0;
            align_oe_r  <= 1'b0;
        end else begin
            div_r       <= div_nxt;
            com_r       <= com_nxt;
            phase_r     <= phase_nxt;
            align_cnt_r <= align_cnt_nxt;
            align_oe_r  <= align_oe_nxt;
        end
    end

    // ======================================================================
    // backplane and segment drive
    always_comb begin
        logic [lsd_pkg::SEGS-1:0] on_bits;
        lsd_pkg::lsd_level_type   lvl;
        on_bits = '0;
        lvl = com_r ? lsd_pkg::LVL_HIGH : lsd_pkg::LVL_LOW;
        if (!dyn) begin
            bp1_nxt = lvl;
            bp2_nxt = lvl;
            on_bits = latch_r[lsd_pkg::SEGS-1:0];
        end else if (sel_b) begin
            bp1_nxt = lsd_pkg::LVL_MID;
            bp2_nxt = lvl;
            on_bits = latch_r[lsd_pkg::STAGES-1:lsd_pkg::SEGS];
        end else begin
            bp1_nxt = lvl;
            bp2_nxt = lsd_pkg::LVL_MID;
            on_bits = latch_r[lsd_pkg::SEGS-1:0];
        end
        if (test) begin
            on_bits = '1;
        end else if (blank) begin
            on_bits = '0;
        end
        seg_nxt  = on_bits ^ {lsd_pkg::SEGS{com_r}};
        cref_nxt = com_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bp1_r  <= lsd_pkg::LVL_LOW;
            bp2_r  <= lsd_pkg::LVL_LOW;
            seg_r  <= '0;
            cref_r <= 1'b0;
        end else begin
            bp1_r  <= bp1_nxt;
            bp2_r  <= bp2_nxt;
            seg_r  <= seg_nxt;
            cref_r <= cref_nxt;
        end
    end

    assign backplane_first      = bp1_r;
    assign backplane_second     = bp2_r;
    assign segment_outputs      = seg_r;
    assign common_reference_out = cref_r;
    assign phase_align_oe       = align_oe_r;

    // ======================================================================
    // ahb-lite register slave
    assign take = hsel & htrans[1] & hready;

    always_comb begin
        ctrl_eff = ctrl_r;
        if (wr_pend_r && (wr_addr_r == lsd_pkg::CTRL_OFS)) begin
            ctrl_eff = hwdata[lsd_pkg::CTRL_W-1:0];
        end
        ctrl_nxt    = ctrl_eff;
        wr_pend_nxt = take & hwrite;
        wr_addr_nxt = haddr[7:0];
        rdata_nxt   = 32'h0000_0000;
        if (take && !hwrite) begin
            if (haddr[7:0] == lsd_pkg::CTRL_OFS) begin
                rdata_nxt = {28'h000_0000, ctrl_eff};
            end else if (haddr[7:0] == lsd_pkg::STAT_OFS) begin
                rdata_nxt = {24'h00_0000, align_s, load_s,
                             shift_r[lsd_pkg::STAGES-1],
                             shift_r[lsd_pkg::SEGS-1],
                             phase_r, sel_b, com_r};
            end
            for (int i = 0; i < lsd_pkg::LATCH_WORDS; i++) begin
                if (haddr[7:0] == lsd_pkg::LATCH_OFS + 8'(4 * i)) begin
                    rdata_nxt = latch_r[32*i +: 32];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r          <= lsd_pkg::CTRL_RESET;
            wr_pend_r       <= 1'b0;
            wr_addr_r       <= 8'h00;
            rdata_r         <= 32'h0000_0000;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
            phase_align_out <= 1'b0;
        end else begin
            ctrl_r          <= ctrl_nxt;
            wr_pend_r       <= wr_pend_nxt;
            wr_addr_r       <= wr_addr_nxt;
            rdata_r         <= rdata_nxt;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
            phase_align_out <= 1'b0;
        end
    end

    assign hrdata = rdata_r;

    // ======================================================================
    // assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence load_held_s;
        load_s ##1 load_s;
    endsequence

    sequence align_start_s;
        dyn && (com_nxt != com_r) && (phase_r == 2'h3);
    endsequence

    shift_on_rise_a: assert property (
        sclk_rise |=> (shift_r[0] == $past(data_s))
                   && (shift_r[lsd_pkg::STAGES-1:1]
                       == $past(shift_r[lsd_pkg::STAGES-2:0])))
        else $error("shift register missed a serial clock rise");

    latch_copy_a: assert property (
        load_held_s |-> latch_r == $past(shift_r))
        else $error("latch did not follow shift register under load");

    latch_hold_a: assert property (
        !load_s |=> $stable(latch_r))
        else $error("latch changed with load low");

    cascade_taps_a: assert property (
        sclk_rise |=> cascade_out_stage80
                      == $past(shift_r[lsd_pkg::SEGS-2])
                   && cascade_out_stage160
                      == $past(shift_r[lsd_pkg::STAGES-2]))
        else $error("cascade output tap wrong");

    static_div_a: assert property (
        (!ext && !dyn && $past(!ext && !dyn) && $past(!ext && !dyn, 2)
            && $changed(com_r))
            |-> $past(div_r[1:0] == 2'h0))
        else $error("static common not a divide by eight");

    ext_follow_a: assert property (
        ext && $past(ext) |-> com_r == $past(osc_s))
        else $error("external common not followed");

    static_bp_a: assert property (
        $past(!dyn) |-> bp1_r == bp2_r
            && bp1_r == ($past(com_r) ? lsd_pkg::LVL_HIGH
                                      : lsd_pkg::LVL_LOW))
        else $error("static backplanes out of phase with common");

    dyn_select_a: assert property (
        $past(dyn) |-> ((bp1_r == lsd_pkg::LVL_MID)
                        != (bp2_r == lsd_pkg::LVL_MID)))
        else $error("dynamic mode needs exactly one idle backplane");

    dyn_half_a: assert property (
        $past(dyn && !test && !blank && sel_b) |-> segment_outputs
            == ($past(latch_r[lsd_pkg::STAGES-1:lsd_pkg::SEGS])
                ^ {lsd_pkg::SEGS{$past(com_r)}}))
        else $error("second latch half not shown");

    test_on_a: assert property (
        $past(test) |-> segment_outputs == ~{lsd_pkg::SEGS{$past(com_r)}})
        else $error("test did not force segments on");

    blank_off_a: assert property (
        $past(blank && !test)
            |-> segment_outputs == {lsd_pkg::SEGS{$past(com_r)}})
        else $error("blank did not force segments off");

    align_pulse_a: assert property (
        align_start_s |=> phase_align_oe [*8])
        else $error("alignment pulse too short");

    align_restart_a: assert property (
        dyn && !align_s |=> phase_r == 2'h0)
        else $error("phase not restarted by low alignment line");

endmodule : lsd_core

/* tb/lsd_host.sv */
`timescale 1ns/1ps
// ==========================================================================
// host model: shifts frames into the core, then strobes load
module lsd_host (
    // clock
    input  wire logic hclk,
    // serial link
    output logic      serial_clock,
    output logic      serial_data,
    output logic      load_strobe
);

    initial begin
        serial_clock = 1'b0;
        serial_data  = 1'b0;
        load_strobe  = 1'b0;
    end

    // ======================================================================
    // one frame, second half first, segment 1 last
    task automatic send_frame(input logic [159:0] bits, input logic load);
        @(posedge hclk);
        for (int i = 159; i >= 0; i--) begin
            serial_data  <= bits[i];
            serial_clock <= 1'b0;
            repeat (4) @(posedge hclk);
            serial_clock <= 1'b1;
            repeat (4) @(posedge hclk);
        end
        serial_clock <= 1'b0;
        serial_data  <= ~bits[0];
        repeat (4) @(posedge hclk);
        if (load) begin
            load_strobe <= 1'b1;
            repeat (4) @(posedge hclk);
            load_strobe <= 1'b0;
            repeat (4) @(posedge hclk);
        end
    endtask : send_frame

endmodule : lsd_host

/* tb/test_lsd_core.sv */
`timescale 1ns/1ps
// ==========================================================================
// bench for the segment driver core
module test_lsd_core;

    logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]            haddr, hwdata, hrdata, rd_q, rdv, exp_w;
    logic [1:0]             htrans, mode;
    logic [2:0]             hsize;
    logic                   serial_clock, serial_data, load_strobe;
    logic                   c80, c160, osc, comref, al_out, al_oe, al_in;
    logic                   rdy_q, oe_seen, ecom, sel2;
    lsd_pkg::lsd_level_type bp1, bp2;
    logic [79:0]            segs;
    logic [7:0]             rises;
    logic [159:0]           fr1;
    int                     miscompares, num_checks, n2;

    // pulled-up shared align line
    assign al_in = al_oe ? al_out : 1'b1;
    assign ecom  = (mode == 2'h2) ? osc : (mode == 2'h1) ? rises[1] : rises[2];

    lsd_core i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .serial_clock(serial_clock),
        .serial_data(serial_data), .load_strobe(load_strobe),
        .cascade_out_stage80(c80), .cascade_out_stage160(c160),
        .oscillator_input(osc), .common_reference_out(comref),
        .phase_align_in(al_in), .phase_align_out(al_out),
        .phase_align_oe(al_oe), .backplane_first(bp1),
        .backplane_second(bp2), .segment_outputs(segs)
    );

    lsd_host i_host (
        .hclk(hclk), .serial_clock(serial_clock),
        .serial_data(serial_data), .load_strobe(load_strobe)
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        rd_q  <= hrdata;
        rdy_q <= hreadyout;
        if (!hresetn) oe_seen <= 1'b0;
        else if (al_oe === 1'b1 && al_out === 1'b0) oe_seen <= 1'b1;
    end

    // ======================================================================
    // compares
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_seg(input logic [79:0] got, input logic [79:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t segments %h expected %h", $time, got, exp);
        end
    endtask : chk_seg

    task automatic chk_lvl(input lsd_pkg::lsd_level_type got,
                           input lsd_pkg::lsd_level_type exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t level %b expected %b", $time, got, exp);
        end
    endtask : chk_lvl

    function automatic lsd_pkg::lsd_level_type lvl(input logic c);
        return c ? lsd_pkg::LVL_HIGH : lsd_pkg::LVL_LOW;
    endfunction : lvl

    // ======================================================================
    // bus and pin drivers
    task automatic wait_rdy();
        do begin
            @(posedge hclk);
            #1;
        end while (rdy_q !== 1'b1);
    endtask : wait_rdy

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        hsize  <= 3'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = rd_q;
    endtask : ahb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk_word(rdv, exp);
        chk_word({31'h0, hresp}, 32'h0000_0000);
    endtask : rd_chk

    task automatic osc_set(input logic v);
        @(posedge hclk);
        osc <= v;
        if (v) rises <= rises + 8'h01;
        repeat (12) @(posedge hclk);
    endtask : osc_set

    task automatic panel(input logic [79:0] on);
        chk_seg(segs, on ^ {80{ecom}});
    endtask : panel

    task automatic end_sim();
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    initial begin
        #1_500_000;
        miscompares++;
        end_sim();
    end

    // ======================================================================
    // main sequence
    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {osc, rises, mode, hresetn} = '0;
        {miscompares, num_checks, n2} = '0;
        fr1 = {80'h0F0F_ABCD_0001_8000_3C5A, 80'hF0F0_1234_8000_0001_C3A5};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(lsd_pkg::CTRL_OFS, 32'h0000_0000);
        rd_chk(lsd_pkg::STAT_OFS, 32'h0000_0080);
        ahb(1'b1, 8'h08, 32'hFFFF_FFFF);
        rd_chk(8'h08, 32'h0000_0000);
        rd_chk(lsd_pkg::LATCH_OFS, 32'h0000_0000);
        i_host.send_frame(fr1, 1'b1);
        chk_word(32'({c160, c80}), 32'({fr1[159], fr1[79]}));
        i_host.send_frame(~fr1, 1'b0);
        chk_word(32'({c160, c80}), 32'({~fr1[159], ~fr1[79]}));
        for (int k = 0; k < 5; k++) begin
            exp_w = fr1[32 * k +: 32];
            rd_chk(lsd_pkg::LATCH_OFS + 8'(4 * k), exp_w);
        end
        for (int i = 0; i < 8; i++) begin
            osc_set(1'b1);
            osc_set(1'b0);
            chk_word({31'h0, comref}, {31'h0, ecom});
            chk_lvl(bp1, lvl(ecom));
            chk_lvl(bp2, lvl(ecom));
            panel(fr1[79:0]);
        end
        ahb(1'b1, lsd_pkg::CTRL_OFS, 32'h0000_000C);
        repeat (4) @(posedge hclk);
        panel({80{1'b1}});
        ahb(1'b1, lsd_pkg::CTRL_OFS, 32'h0000_0008);
        repeat (4) @(posedge hclk);
        panel({80{1'b0}});
        ahb(1'b1, lsd_pkg::CTRL_OFS, 32'h0000_0000);
        repeat (4) @(posedge hclk);
        panel(fr1[79:0]);
        ahb(1'b1, lsd_pkg::CTRL_OFS, 32'h0000_0001);
        mode = 2'h1;
        for (int i = 0; i < 16; i++) begin
            osc_set(1'b1);
            osc_set(1'b0);
            sel2 = (bp1 === lsd_pkg::LVL_MID);
            n2 += int'(sel2);
            chk_word({31'h0, comref}, {31'h0, ecom});
            chk_word({31'h0, sel2 ^ (bp2 === lsd_pkg::LVL_MID)},
                     32'h0000_0001);
            chk_lvl(sel2 ? bp2 : bp1, lvl(ecom));
            panel(sel2 ? fr1[159:80] : fr1[79:0]);
        end
        chk_word(n2, 32'h0000_0008);
        chk_word({31'h0, oe_seen}, 32'h0000_0001);
        ahb(1'b1, lsd_pkg::CTRL_OFS, 32'h0000_0002);
        mode = 2'h2;
        for (int i = 0; i < 2; i++) begin
            osc_set(i == 0);
            chk_word({31'h0, comref}, {31'h0, ecom});
            panel(fr1[79:0]);
        end
        end_sim();
    end

endmodule : test_lsd_core
